// *** fct_timer.v ***
// Purpose: Fixed-cycle down-count timer with open-drain style interrupt
// Assumes: All inputs synchronous to clk_i; AXI4-Lite master on the bus
// Notes:   Interrupt pin is drive-low only: level 0 whenever enabled
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "fct_consts.vh"

// How it works
// (R1) A timer event sets timer_flag, held until software writes zero.
// (R2) Writing 0 clears timer_flag; writing 1 leaves it unchanged.
// (R3) Event with irq enable set drives timer_irq_n low, else pin stays released.
// (R4) Dropping timer_irq_enable while pin is low releases it at once, any mode.
// (R5) Countdown starts at the write that turns timer_enable from zero to one.
// (R6) Each start loads the counter from the preset, never an old count.
// (R7) Counter steps down once per source tick; event on the tick at count 1, which reloads the preset.
// (R8) Interval is source period times preset; preset zero is not valid.
// (R9) Free-running source ticks make first interval up to one period short.
// (R10) Clearing timer_enable keeps timer_flag; in level mode pin unchanged.
// (R11) In level mode clearing timer_flag releases the pin regardless of enable.
// (R12) Level mode gives one event per start; enable then gates pin freely.
// (R13) Software clears timer_enable and timer_flag before each level-mode start.
// (R14) Repeated mode reloads the preset after each event and keeps counting.
// (R15) Repeated mode holds pin low for the hold time, then releases it.
// (R16) Repeated mode: writing timer_enable zero stops and releases pin at once.
// (R17) Repeated mode: clearing timer_flag does not cut the low pulse short.
// (R18) Select codes pick 4096, 64, 1 or 1/60 Hz; hold time 122 us or 7.813 ms.
// (R19) repeat_mode_select zero is level mode, one is repeated pulse mode.
// (R20) Software programs the preset between 1 and 255 before starting.
// (R21) Minute tick follows minute rollover; 1 Hz comes from the divider shared with 4096 and 64 Hz.
// (R22) Source ticks derive from a 32768 Hz divider, one cycle per period.
// (R23) Event and flag clear in the same cycle: the event wins.
module fct_timer #(
  parameter [18:0] HOLD_FAST_CYC = `FCT_HOLD_FAST_CYC,
  parameter [18:0] HOLD_SLOW_CYC = `FCT_HOLD_SLOW_CYC
) (
  input  wire                   clk_i,
  input  wire                   rst_i,
  input  wire [`FCT_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire                   s_axi_awvalid_i,
  output wire                   s_axi_awready_o,
  input  wire [31:0]            s_axi_wdata_i,
  input  wire [3:0]             s_axi_wstrb_i,
  input  wire                   s_axi_wvalid_i,
  output wire                   s_axi_wready_o,
  output wire [1:0]             s_axi_bresp_o,
  output wire                   s_axi_bvalid_o,
  input  wire                   s_axi_bready_i,
  input  wire [`FCT_ADDR_W-1:0] s_axi_araddr_i,
  input  wire                   s_axi_arvalid_i,
  output wire                   s_axi_arready_o,
  output wire [31:0]            s_axi_rdata_o,
  output wire [1:0]             s_axi_rresp_o,
  output wire                   s_axi_rvalid_o,
  input  wire                   s_axi_rready_i,
  output wire                   timer_irq_n_o,
  output wire                   timer_irq_oe_o
);

  // Register index 4 means unmapped
  function [2:0] fct_dec;
    input [`FCT_ADDR_W-1:0] a;
    begin
      case (a)
        `FCT_REG_SETUP:  fct_dec = 3'h0;
        `FCT_REG_PRESET: fct_dec = 3'h1;
        `FCT_REG_CTRL:   fct_dec = 3'h2;
        `FCT_REG_STATUS: fct_dec = 3'h3;
        default:         fct_dec = 3'h4;
      endcase
    end
  endfunction

  // Bus slave state
  reg                   aw_ok_q;
  reg [`FCT_ADDR_W-1:0] aw_addr_q;
  reg                   w_ok_q;
  reg [31:0]            w_data_q;
  reg                   w_strb_q;
  reg                   bvalid_q;
  reg [1:0]             bresp_q;
  reg                   rvalid_q;
  reg [1:0]             rresp_q;
  reg [31:0]            rdata_q;

  // Software-visible control
  reg                   te_q;
  reg [1:0]             sel_q;
  reg [7:0]             preset_q;
  reg                   repeat_q;
  reg                   flag_q;
  reg                   ie_q;

  // Timer core
  reg [25:0]            nco_q;
  reg                   osc_tick_q;
  reg [14:0]            pre_q;
  reg [5:0]             min_q;
  reg                   run_q;
  reg [7:0]             cnt_q;
  reg                   pulse_q;
  reg [18:0]            hold_q;
  reg                   irq_oe_q;

  wire [26:0] nco_sum = {1'b0, nco_q} + {1'b0, `FCT_NCO_STEP};
  wire        nco_wrap = nco_sum >= {1'b0, `FCT_NCO_MOD};

  wire        wr_go = aw_ok_q & w_ok_q & ~bvalid_q;
  wire [2:0]  wr_sel = fct_dec(aw_addr_q);
  wire        wr_en = wr_go & w_strb_q;
  wire        we_setup = wr_en & (wr_sel == 3'h0);
  wire        we_preset = wr_en & (wr_sel == 3'h1);
  wire        we_ctrl = wr_en & (wr_sel == 3'h2);
  wire        new_te = w_data_q[`FCT_TE_BIT];
  wire        new_ie = w_data_q[`FCT_IE_BIT];
  wire        start = we_setup & new_te & ~te_q;
  wire        stop = we_setup & ~new_te;
  wire        flag_clr = we_ctrl & ~w_data_q[`FCT_FLAG_BIT];

  // Source tick selection
  reg         src_tick;
  wire        sec_tick = osc_tick_q & ((pre_q & `FCT_DIV_1HZ_MASK) == `FCT_DIV_1HZ_MASK);

  always @*
  begin
    case (sel_q)
      `FCT_SEL_4096HZ:
        src_tick = osc_tick_q & ((pre_q & `FCT_DIV_4096_MASK) == `FCT_DIV_4096_MASK);
      `FCT_SEL_64HZ:
        src_tick = osc_tick_q & ((pre_q & `FCT_DIV_64_MASK) == `FCT_DIV_64_MASK);
      `FCT_SEL_1HZ:
        src_tick = sec_tick; // R21
      `FCT_SEL_1MIN:
        src_tick = sec_tick & (min_q == `FCT_MIN_LAST); // R21
      default:
        src_tick = 1'b0;
    endcase
  end

  wire        event_w = run_q & src_tick & (cnt_q == 8'h01); // R7
  wire [18:0] hold_len = (sel_q == `FCT_SEL_4096HZ) ? HOLD_FAST_CYC : HOLD_SLOW_CYC; // R18

  // Pin level for the next cycle; repeated mode ignores the flag here
  wire        irq_d = repeat_q ? (pulse_q & ie_q) : (flag_q & ie_q); // R4 R11 R12 R17 R19

  // AXI4-Lite write channel: address and data taken in either order
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_ok_q   <= 1'b0;
      aw_addr_q <= {`FCT_ADDR_W{1'b0}};
      w_ok_q    <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `FCT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i & s_axi_awready_o)
      begin
        aw_ok_q   <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i & s_axi_wready_o)
      begin
        w_ok_q   <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i[0];
      end
      if (wr_go)
      begin
        aw_ok_q  <= 1'b0;
        w_ok_q   <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_sel == 3'h4) ? `FCT_RESP_SLVERR : `FCT_RESP_OKAY;
      end
      else if (bvalid_q & s_axi_bready_i)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel: data one cycle after the address is taken
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= `FCT_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end
    else if (s_axi_arvalid_i & s_axi_arready_o)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= `FCT_RESP_OKAY;
      case (fct_dec(s_axi_araddr_i))
        3'h0:
          rdata_q <= {24'h00_0000, te_q, 1'b0, sel_q, 4'h0};
        3'h1:
          rdata_q <= {24'h00_0000, preset_q};
        3'h2:
          rdata_q <= {27'h000_0000, repeat_q, 1'b0, flag_q, 1'b0, ie_q};
        3'h3:
          rdata_q <= {16'h0000, cnt_q, 5'h00, pulse_q, run_q, irq_oe_q};
        default:
        begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `FCT_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q & s_axi_rready_i)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // Control registers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      te_q     <= 1'b0;
      sel_q    <= `FCT_SEL_4096HZ;
      preset_q <= `FCT_RST_PRESET;
      repeat_q <= 1'b0;
      flag_q   <= 1'b0;
      ie_q     <= 1'b0;
    end
    else
    begin
      if (we_setup)
      begin
        te_q  <= new_te;
        sel_q <= {w_data_q[`FCT_SEL_HI_BIT], w_data_q[`FCT_SEL_LO_BIT]};
      end
      if (we_preset)
      begin
        preset_q <= w_data_q[7:0];
      end
      if (we_ctrl)
      begin
        repeat_q <= w_data_q[`FCT_REPEAT_BIT];
        ie_q     <= new_ie;
      end
      // Set beats clear so a coinciding event is never lost
      if (event_w)
        flag_q <= 1'b1; // R1 R23
      else if (flag_clr)
        flag_q <= 1'b0; // R2 R11
    end
  end

  // 32768 Hz reference by fractional accumulation, then free dividers.
  // Dividers never restart, so the start phase is random within one period.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      nco_q      <= 26'h000_0000;
      osc_tick_q <= 1'b0;
      pre_q      <= 15'h0000;
      min_q      <= 6'h00;
    end
    else
    begin
      nco_q      <= nco_wrap ? nco_sum[25:0] - `FCT_NCO_MOD : nco_sum[25:0]; // R22
      osc_tick_q <= nco_wrap; // R22
      if (osc_tick_q)
        pre_q <= pre_q + 15'h0001; // R9
      if (sec_tick)
        min_q <= (min_q == `FCT_MIN_LAST) ? 6'h00 : min_q + 6'h01; // R21
    end
  end

  // Down counter and repeated-mode pulse
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_q    <= 1'b0;
      cnt_q    <= 8'h00;
      pulse_q  <= 1'b0;
      hold_q   <= 19'h0_0000;
      irq_oe_q <= 1'b0;
    end
    else
    begin
      if (start)
      begin
        run_q <= 1'b1; // R5
        cnt_q <= preset_q; // R6 R8
      end
      else if (stop)
      begin
        run_q <= 1'b0; // R10 R16
      end
      else if (run_q & src_tick)
      begin
        if (cnt_q == 8'h01)
        begin
          cnt_q <= preset_q; // R14
          run_q <= repeat_q; // R12 R19
        end
        else
        begin
          cnt_q <= cnt_q - 8'h01; // R7
        end
      end
      if (stop & repeat_q)
      begin
        pulse_q <= 1'b0; // R16
      end
      else if (event_w & repeat_q & ie_q)
      begin
        pulse_q <= 1'b1; // R3 R15
        hold_q  <= hold_len; // R15
      end
      else if (pulse_q)
      begin
        if (hold_q == 19'h0_0001)
          pulse_q <= 1'b0; // R15 R17
        hold_q <= hold_q - 19'h0_0001;
      end
      // Registered pin: level-mode event shows as flag one cycle later
      irq_oe_q <= irq_d & ~(stop & repeat_q); // R3 R4
    end
  end

  assign s_axi_awready_o = ~aw_ok_q & ~bvalid_q;
  assign s_axi_wready_o  = ~w_ok_q & ~bvalid_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = ~rvalid_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rresp_o   = rresp_q;
  assign s_axi_rdata_o   = rdata_q;
  assign timer_irq_n_o   = 1'b0;
  assign timer_irq_oe_o  = irq_oe_q;

endmodule
`default_nettype wire

// *** fct_consts.vh ***
// Purpose: Constants for the fixed-cycle timer interrupt block
// Assumes: 50 MHz system clock, 32768 Hz oscillator made by an NCO
// Notes:   Register map sits on AXI4-Lite, one word per register
`ifndef FCT_CONSTS_VH
`define FCT_CONSTS_VH

`define FCT_ADDR_W        4
`define FCT_REG_SETUP     4'h0
`define FCT_REG_PRESET    4'h4
`define FCT_REG_CTRL      4'h8
`define FCT_REG_STATUS    4'hc

`define FCT_TE_BIT        7
`define FCT_SEL_HI_BIT    5
`define FCT_SEL_LO_BIT    4
`define FCT_REPEAT_BIT    4
`define FCT_FLAG_BIT      2
`define FCT_IE_BIT        0

`define FCT_RESP_OKAY     2'h0
`define FCT_RESP_SLVERR   2'h2

`define FCT_SEL_4096HZ    2'h0
`define FCT_SEL_64HZ      2'h1
`define FCT_SEL_1HZ       2'h2
`define FCT_SEL_1MIN      2'h3

`define FCT_CLK_MHZ       50
`define FCT_NCO_STEP      26'h0008000
`define FCT_NCO_MOD       26'h2faf080
`define FCT_DIV_4096_MASK 15'h0007
`define FCT_DIV_64_MASK   15'h01ff
`define FCT_DIV_1HZ_MASK  15'h7fff
`define FCT_MIN_LAST      6'h3b

`define FCT_HOLD_FAST_NS  122000
`define FCT_HOLD_SLOW_NS  7813000
`define FCT_HOLD_FAST_CYC 19'h017d4
`define FCT_HOLD_SLOW_CYC 19'h5f5fa

`define FCT_RST_PRESET    8'h00
`endif

// *** fct_timer_properties.sv ***
// Purpose: Port checks for fct_timer
// Assumes: Write address and data offered together
// Notes:   Mode shadow rebuilt from bus writes
`timescale 1ns/1ps
`default_nettype none
module fct_timer_checker #(
  parameter [18:0] HOLD_FAST_CYC = 19'd8
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0]  s_axi_wstrb_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        timer_irq_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       rep_q;
  logic [7:0] hi_q;
  wire        wr = s_axi_awvalid_i & s_axi_awready_o & s_axi_wvalid_i & s_axi_wready_o
                   & s_axi_wstrb_i[0];
  wire  [7:0] wd = s_axi_wdata_i[7:0];
  wire        oe = timer_irq_oe_o;
  wire        a0 = s_axi_awaddr_i == 4'h0;
  wire        a8 = s_axi_awaddr_i == 4'h8;
  // Pulse age lets the keep check stay clear of the natural pulse end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rep_q <= 1'b0;
      hi_q  <= 8'h00;
    end
    else
    begin
      if (wr && a8)
        rep_q <= wd[4];
      hi_q <= oe ? hi_q + 8'h01 : 8'h00;
    end
  end
  AST_WR_LAT: assert property (wr |-> ##2 s_axi_bvalid_o)
    else $error("no write response");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped");
  AST_RD_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("no read response");
  AST_IE_DROP: assert property (wr && a8 && !wd[0] |-> ##[1:3] !oe)
    else $error("pin held after enable cleared");
  AST_LVL_CLR: assert property (wr && a8 && !wd[2] && !wd[4] |-> ##[1:3] !oe)
    else $error("pin held after flag cleared");
  AST_REP_STOP: assert property (wr && a0 && !wd[7] && rep_q |-> ##[1:3] !oe)
    else $error("pin held after stop");
  AST_REP_END: assert property (rep_q && $rose(oe) |-> ##[1:48] !oe)
    else $error("pulse did not end");
  AST_REP_KEEP: assert property (wr && a8 && wd[4] && wd[0] && rep_q && oe
    && ({11'h0, hi_q} + 19'd8 < HOLD_FAST_CYC) |-> ##2 oe)
    else $error("pulse cut short");
  cover property (rep_q && $fell(oe));
  cover property (!rep_q && $rose(oe));
  cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule
bind fct_timer fct_timer_checker #(.HOLD_FAST_CYC(HOLD_FAST_CYC)) fct_timer_checker_inst (
  .clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
  .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .timer_irq_oe_o);
`default_nettype wire

// *** fct_host_model.sv ***
// Purpose: Host side of the timer interrupt pin
// Assumes: External pull-up on the pin
// Notes:   Released pin reads high, never a stale value
`timescale 1ns/1ps
`default_nettype none
module fct_host_model (
  input  wire logic irq_n_i,
  input  wire logic irq_oe_i,
  output logic      irq_line_o
);
  assign irq_line_o = irq_oe_i ? irq_n_i : 1'b1;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench for fct_timer
// Assumes: 4096 Hz tick about every 12207 cycles; pulse hold cut to 40 (fast) and 60 (slow)
// Notes:   One task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int HF = 40;
  localparam int TK = 12207;
  logic        clk_i = 1'b0, rst_i = 1'b1, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic        s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [3:0]  s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'hf;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, d;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rr, br;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic        s_axi_rvalid_o, timer_irq_n_o, timer_irq_oe_o, irq_line;
  int          mismatches = 0, n_checks = 0, cyc = 0, n;
  always #10 clk_i = ~clk_i;
  fct_timer #(.HOLD_FAST_CYC(19'd40), .HOLD_SLOW_CYC(19'd60)) fct_timer_inst (
    .clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .timer_irq_n_o, .timer_irq_oe_o);
  fct_host_model fct_host_model_inst (
    .irq_n_i(timer_irq_n_o), .irq_oe_i(timer_irq_oe_o), .irq_line_o(irq_line));
  task automatic stop_test();
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_checks++;
      if (g !== e)
      begin
        mismatches++;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    begin
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= {24'h0, v};
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do
      begin
        @(posedge clk_i);
        if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
        if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (!s_axi_bvalid_o);
      br = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
      // One idle edge so a following call never re-raises bready in this step
      @(posedge clk_i);
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    begin
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do
      begin
        @(posedge clk_i);
        if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (!s_axi_rvalid_o);
      v = s_axi_rdata_o;
      rr = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  // Pin is registered behind the register write, so allow its lag
  task automatic pin(input logic v);
    begin
      repeat (3) @(posedge clk_i);
      chk("pin", {31'h0, v}, {31'h0, irq_line});
    end
  endtask
  task automatic wt(input logic v, input int mx, output int c);
    begin
      c = 0;
      while (irq_line !== v && c < mx)
      begin
        @(posedge clk_i);
        c++;
      end
    end
  endtask
  task automatic t_regs();
    begin
      rd(4'h4, d);
      chk("preset", 32'h0, d);
      rd(4'h8, d);
      chk("ctrl", 32'h0, d);
      rd(4'h2, d);
      chk("unmapped", 32'h2, {30'h0, rr});
      wr(4'h2, 8'hff);
      chk("unmapped bresp", 32'h2, {30'h0, br});
      for (int i = 0; i < 4; i++)
      begin
        wr(4'h0, 8'(i << 4));
        rd(4'h0, d);
        chk("select", 32'(i << 4), d);
      end
      chk("bresp ok", 32'h0, {30'h0, br});
    end
  endtask
  task automatic t_level();
    begin
      wr(4'h8, 8'h01);
      wr(4'h0, 8'h00);
      wr(4'h4, 8'h02);
      wr(4'h0, 8'h80);
      wt(1'b0, 3 * TK, n);
      chk("gap", 32'h1, 32'(n >= TK - 8 && n <= 2 * TK + 8));
      rd(4'h8, d);
      chk("flag", 32'h5, d & 32'h15);
      wr(4'h8, 8'h04);
      pin(1'b1);
      wr(4'h8, 8'h05);
      pin(1'b0);
      wr(4'h8, 8'h01);
      pin(1'b1);
      rd(4'h8, d);
      chk("flag clr", 32'h1, d & 32'h15);
      wt(1'b0, 2 * TK + 100, n);
      chk("one shot", 32'(2 * TK + 100), 32'(n));
    end
  endtask
  task automatic t_repeat();
    begin
      wr(4'h0, 8'h00);
      wr(4'h8, 8'h11);
      wr(4'h4, 8'h01);
      wr(4'h0, 8'h80);
      rd(4'hc, d);
      chk("count", 32'h0102, d & 32'hff02);
      wt(1'b0, TK + 100, n);
      wt(1'b1, 100, n);
      chk("hold", 32'h1, 32'(n >= HF - 2 && n <= HF + 2));
      wt(1'b0, TK + 100, n);
      chk("period", 32'h1, 32'(n >= TK - HF - 8 && n <= TK - HF + 8));
      wr(4'h8, 8'h11);
      pin(1'b0);
      wt(1'b1, 100, n);
      wt(1'b0, TK + 100, n);
      wr(4'h0, 8'h00);
      pin(1'b1);
      rd(4'h8, d);
      chk("flag kept", 32'h15, d & 32'h15);
    end
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_level();
    t_repeat();
    stop_test();
  end
endmodule
`default_nettype wire
